/* logic/timer_pkg.sv */
// Purpose: Shared constants and types of the three-channel reload timer
// Assumes: 8-bit byte address, 32-bit data, one word per register
// Notes:   Control bits 9:0 map one to one onto ctrl_s
package timer_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] RUN_OFF = 8'h00;
    localparam logic [7:0] CTRL_BASE = 8'h04;
    localparam logic [7:0] RELOAD_BASE = 8'h10;
    localparam logic [7:0] COUNT_BASE = 8'h1c;
    localparam logic [7:0] CAPTURE_OFF = 8'h28;
    localparam logic [7:0] SLOT_SPAN = 8'h0c;

    // ------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------
    localparam int CHANNELS = 3;
    localparam int CAP_CHANNEL = 2;
    localparam int RUN_W = 3;
    localparam int CTRL_W = 10;
    localparam int DIV_W = 8;
    localparam logic [31:0] RELOAD_RST = 32'h0fffffff;
    localparam logic [31:0] COUNT_RST = 32'h0fffffff;
    localparam logic [RUN_W-1:0] RUN_RST = 3'h0;

    // ------------------------------------------------------------
    // Field encodings
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        PSC_DIV4 = 3'b000,
        PSC_DIV16 = 3'b001,
        PSC_DIV64 = 3'b010,
        PSC_DIV256 = 3'b011,
        PSC_EXT = 3'b101
    } psc_e;

    typedef enum logic [1:0] {
        CAP_OFF = 2'b00,
        CAP_BAD = 2'b01,
        CAP_ON = 2'b10,
        CAP_IRQ = 2'b11
    } cap_e;

    typedef enum logic [1:0] {
        EDGE_RISE = 2'b00,
        EDGE_FALL = 2'b01
    } edge_e;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic capture_flag;
        logic underflow_flag;
        logic [1:0] capture_mode;
        logic underflow_irq_enable;
        logic [1:0] edge_select;
        logic [2:0] prescale_sel;
    } ctrl_s;

    localparam ctrl_s CTRL_RST = 10'h000;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } bus_req_s;

endpackage

/* logic/reload_timer_with_capture.sv */
// Purpose: Three 32-bit auto-reload down counters, capture on channel 2
// Assumes: Single clock mclk, synchronous active-high reset
// Notes:   Registers over a plain strobe port, read data one cycle later
//
// Function
// - Capture flag, bit 9 of channel 2 control, sets on a capture request.
// - Flags clear only on a written 0; a written 1 keeps them.
// - Underflow flag, bit 8 of each channel control, sets on underflow.
// - Capture mode 00 off, 01 prohibited, 10 on, 11 on with interrupt.
// - Underflow interrupt enable at bit 5 gates the underflow interrupt.
// - Edge field: 00 rising, 01 falling, 1X both; counting and capture.
// - Prescale: 000 /4, 001 /16, 010 /64, 011 /256, 101 pin.
// - Control bits 15 to 10 read zero; software writes zero there.
// - On underflow the counter loads its reload constant at once.
// - Reload constant is 32-bit read/write, reset to 0fffffff.
// - Counter decrements by one on each selected count tick.
// - Decrement from zero is underflow and sets the underflow flag.
// - Counter resets to the 0fffffff initial value.
// - Capture register copies channel 2 counter on a capture event.
// - Capture register has no reset value.
// - Three channels with counter and reload; capture only on 2.
// - Per-channel run bit: 0 holds the counter, 1 counts; reset 0.
// - Interrupt asserted only while its flag and enable are both 1.
module reload_timer_with_capture #(
    parameter int CHANNELS = timer_pkg::CHANNELS
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic ce,
    input wire timer_pkg::bus_req_s bus,
    output logic [31:0] rdata,
    input wire logic external_timer_pin,
    output logic [CHANNELS-1:0] underflow_interrupt,
    output logic capture_interrupt
);

    // ------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------
    // Hit flag and channel index of a three-word register group
    function automatic logic [2:0] slot(
        input logic [7:0] a,
        input logic [7:0] base
    );
        logic [7:0] d;
        d = a - base;
        slot = {(a[1:0] == 2'b00) && (a >= base) &&
                (d < timer_pkg::SLOT_SPAN), d[3:2]};
    endfunction

    function automatic logic edge_hit(
        input logic [1:0] sel,
        input logic rise,
        input logic fall
    );
        if (sel[1])
        begin
            edge_hit = rise | fall;
        end
        else if (sel == timer_pkg::EDGE_FALL)
        begin
            edge_hit = fall;
        end
        else
        begin
            edge_hit = rise;
        end
    endfunction

    // Prohibited codes give no tick, so the counter simply holds
    function automatic logic count_tick(
        input logic [2:0] psc,
        input logic [timer_pkg::DIV_W-1:0] div,
        input logic ext
    );
        case (psc)
            timer_pkg::PSC_DIV4: count_tick = &div[1:0];
            timer_pkg::PSC_DIV16: count_tick = &div[3:0];
            timer_pkg::PSC_DIV64: count_tick = &div[5:0];
            timer_pkg::PSC_DIV256: count_tick = &div[7:0];
            timer_pkg::PSC_EXT: count_tick = ext;
            default: count_tick = 1'b0;
        endcase
    endfunction

    // Write strobe for member ch of a three-word register group
    function automatic logic chan_wr(
        input logic wr,
        input logic [2:0] hit,
        input int ch
    );
        chan_wr = wr && hit[2] && (hit[1:0] == 2'(ch));
    endfunction

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire logic [2:0] ctl_slot;
    wire logic [2:0] rel_slot;
    wire logic [2:0] cnt_slot;
    wire logic run_hit;
    wire logic cap_hit;
    wire logic wr_run;

    assign ctl_slot = slot(bus.addr, timer_pkg::CTRL_BASE);
    assign rel_slot = slot(bus.addr, timer_pkg::RELOAD_BASE);
    assign cnt_slot = slot(bus.addr, timer_pkg::COUNT_BASE);
    assign run_hit = bus.addr == timer_pkg::RUN_OFF;
    assign cap_hit = bus.addr == timer_pkg::CAPTURE_OFF;
    assign wr_run = bus.wr && run_hit;

    // ------------------------------------------------------------
    // Pin synchroniser and edge detector
    // ------------------------------------------------------------
    logic pin_meta_q;
    logic pin_sync_q;
    logic pin_last_q;
    wire logic pin_rise;
    wire logic pin_fall;
    logic [1:0] warm_q;
    wire logic pin_ok;

    // Two stages for metastability, third only for the edge compare
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            pin_meta_q <= 1'b0;
            pin_sync_q <= 1'b0;
            pin_last_q <= 1'b0;
            warm_q <= 2'h0;
        end
        else if (ce)
        begin
            pin_meta_q <= external_timer_pin;
            pin_sync_q <= pin_meta_q;
            pin_last_q <= pin_sync_q;
            if (!(&warm_q))
            begin
                warm_q <= warm_q + 2'h1;
            end
        end
    end

    // Edges masked until the pipe holds real pin levels,
    // so a pin idling high gives no false edge after reset
    assign pin_ok = &warm_q;
    assign pin_rise = pin_ok && pin_sync_q && !pin_last_q;
    assign pin_fall = pin_ok && !pin_sync_q && pin_last_q;

    // ------------------------------------------------------------
    // Shared prescaler and run register
    // ------------------------------------------------------------
    logic [timer_pkg::DIV_W-1:0] div_q;
    logic [timer_pkg::RUN_W-1:0] run_q;

    // One free-running divider serves all channels and all ratios
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            div_q <= '0;
            run_q <= timer_pkg::RUN_RST;
        end
        else if (ce)
        begin
            div_q <= div_q + 1'b1;
            if (wr_run)
            begin
                run_q <= bus.wdata[timer_pkg::RUN_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Capture on channel 2
    // ------------------------------------------------------------
    logic [31:0] cnt_w [CHANNELS];
    logic [31:0] rel_w [CHANNELS];
    timer_pkg::ctrl_s ctl_w [CHANNELS];
    logic [CHANNELS-1:0] uirq_d;
    logic cirq_d;
    logic [31:0] cap_q;
    wire logic cap_evt;
    wire timer_pkg::ctrl_s cap_ctl;

    assign cap_ctl = ctl_w[timer_pkg::CAP_CHANNEL];
    // Mode 01 is treated as off since only the high bit enables
    assign cap_evt = cap_ctl.capture_mode[1] &&
                     edge_hit(cap_ctl.edge_select, pin_rise, pin_fall);

    // No reset here: content is undefined until the first capture
    always_ff @(posedge mclk)
    begin
        if (ce && cap_evt)
        begin
            cap_q <= cnt_w[timer_pkg::CAP_CHANNEL];
        end
    end

    // ------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------
    for (genvar i = 0; i < CHANNELS; i++)
    begin : chan
        localparam logic HAS_CAP = (i == timer_pkg::CAP_CHANNEL);
        logic [31:0] cnt_q;
        logic [31:0] rel_q;
        timer_pkg::ctrl_s ctl_q;
        timer_pkg::ctrl_s ctl_d;
        timer_pkg::ctrl_s wr_ctl_val;
        wire logic wr_ctl;
        wire logic wr_rel;
        wire logic wr_cnt;
        wire logic ext_hit;
        wire logic tick;
        wire logic unf_evt;
        wire logic cap_set;
        wire logic clr_unf;
        wire logic clr_cap;

        assign wr_ctl = chan_wr(bus.wr, ctl_slot, i);
        assign wr_rel = chan_wr(bus.wr, rel_slot, i);
        assign wr_cnt = chan_wr(bus.wr, cnt_slot, i);
        assign wr_ctl_val = bus.wdata[timer_pkg::CTRL_W-1:0];

        assign ext_hit = edge_hit(ctl_q.edge_select, pin_rise, pin_fall);
        assign tick = run_q[i] &&
                      count_tick(ctl_q.prescale_sel, div_q, ext_hit);
        // A software write to the counter takes precedence over a tick
        assign unf_evt = tick && !wr_cnt && (cnt_q == '0);
        assign cap_set = HAS_CAP && cap_evt;
        assign clr_unf = wr_ctl && !wr_ctl_val.underflow_flag;
        assign clr_cap = wr_ctl && !wr_ctl_val.capture_flag;

        // Set beats clear so an event in the clearing cycle survives
        always_comb
        begin
            ctl_d = ctl_q;
            if (wr_ctl)
            begin
                ctl_d.underflow_irq_enable = wr_ctl_val.underflow_irq_enable;
                ctl_d.edge_select = wr_ctl_val.edge_select;
                ctl_d.prescale_sel = wr_ctl_val.prescale_sel;
                ctl_d.capture_mode = HAS_CAP ? wr_ctl_val.capture_mode : 2'b00;
            end
            ctl_d.underflow_flag = unf_evt ||
                                   (ctl_q.underflow_flag && !clr_unf);
            ctl_d.capture_flag = HAS_CAP &&
                                 (cap_set || (ctl_q.capture_flag && !clr_cap));
        end

        always_ff @(posedge mclk)
        begin
            if (reset)
            begin
                ctl_q <= timer_pkg::CTRL_RST;
                rel_q <= timer_pkg::RELOAD_RST;
                cnt_q <= timer_pkg::COUNT_RST;
            end
            else if (ce)
            begin
                ctl_q <= ctl_d;
                if (wr_rel)
                begin
                    rel_q <= bus.wdata;
                end
                if (wr_cnt)
                begin
                    cnt_q <= bus.wdata;
                end
                else if (unf_evt)
                begin
                    cnt_q <= rel_q;
                end
                else if (tick)
                begin
                    cnt_q <= cnt_q - 32'h00000001;
                end
            end
        end

        // Next-state terms keep the registered request in step with flags
        assign uirq_d[i] = ctl_d.underflow_flag && ctl_d.underflow_irq_enable;
        assign cnt_w[i] = cnt_q;
        assign rel_w[i] = rel_q;
        assign ctl_w[i] = ctl_q;
    end

    // ------------------------------------------------------------
    // Capture interrupt
    // ------------------------------------------------------------
    // Built from next-state flag and mode, so a clearing write
    // drops the request at the same edge as the flag

    assign cirq_d = ctl_w[timer_pkg::CAP_CHANNEL].capture_flag ||
                    chan[timer_pkg::CAP_CHANNEL].cap_set;
    wire logic cirq_en;
    wire logic cirq_keep;
    wire timer_pkg::ctrl_s cap_ctl_d;

    assign cap_ctl_d = chan[timer_pkg::CAP_CHANNEL].ctl_d;
    assign cirq_en = cap_ctl_d.capture_mode == timer_pkg::CAP_IRQ;
    assign cirq_keep = cirq_d && cap_ctl_d.capture_flag;

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    wire logic [31:0] rd_mux;
    wire logic [31:0] ctl_rd;
    wire timer_pkg::ctrl_s ctl_sel;

    // Reads have no side effects; a same-cycle tick is not yet seen
    assign ctl_sel = ctl_w[ctl_slot[1:0]];
    assign ctl_rd = {22'h000000, ctl_sel};
    assign rd_mux = run_hit ? {29'h00000000, run_q} :
                    ctl_slot[2] ? ctl_rd :
                    rel_slot[2] ? rel_w[rel_slot[1:0]] :
                    cnt_slot[2] ? cnt_w[cnt_slot[1:0]] :
                    cap_hit ? cap_q :
                    32'h00000000;

    // ------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            rdata <= 32'h00000000;
            underflow_interrupt <= '0;
            capture_interrupt <= 1'b0;
        end
        else if (ce)
        begin
            // Data stands for one cycle only, zero otherwise
            rdata <= bus.rd ? rd_mux : 32'h00000000;
            underflow_interrupt <= uirq_d;
            capture_interrupt <= cirq_keep && cirq_en;
        end
    end

endmodule

/* verification/timer_monitor.sv */
// Purpose: Port-level checks of the reload timer
// Assumes: ce held high
// Notes:   Pin quiet time is counted to tell captures from writes
module timer_monitor #(
    parameter int CHANNELS = 3
) (
    input wire logic mclk,
    input wire logic reset,
    input wire timer_pkg::bus_req_s bus,
    input wire logic [31:0] rdata,
    input wire logic external_timer_pin,
    input wire logic [CHANNELS-1:0] underflow_interrupt,
    input wire logic capture_interrupt
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] quiet_q;
    logic pin_q;
    logic [2:0] run_q;
    wire logic [31:0] wd = bus.wdata;
    wire logic wr_s = bus.wr;
    wire logic rd_cap = bus.rd && bus.addr == timer_pkg::CAPTURE_OFF;
    wire logic wr_ctl2 = bus.wr && bus.addr == 8'h0c;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    always_ff @(posedge mclk)
    begin
        pin_q <= external_timer_pin;
        if (reset)
        begin
            quiet_q <= 4'hf;
            run_q <= 3'h0;
        end
        else
        begin
            quiet_q <= (pin_q != external_timer_pin) ? 4'h0 : quiet_q + {3'h0, quiet_q != 4'hf};
            if (bus.wr && bus.addr == timer_pkg::RUN_OFF)
                run_q <= bus.wdata[2:0];
        end
    end
    chk_ctrl_reserved: assert property (
        bus.rd && bus.addr inside {8'h04, 8'h08, 8'h0c} |=> rdata[31:10] == 22'h0)
        else $error("control upper bits nonzero");
    chk_run_reserved: assert property (
        bus.rd && bus.addr == timer_pkg::RUN_OFF |=> rdata[31:3] == 29'h0)
        else $error("run upper bits nonzero");
    chk_count_hold: assert property (
        bus.rd && bus.addr == timer_pkg::COUNT_BASE && !run_q[0] ##1 !bus.wr
        ##1 bus.rd && bus.addr == timer_pkg::COUNT_BASE |=> rdata == $past(rdata, 2))
        else $error("halted counter moved");
    chk_reload_back: assert property (
        bus.wr && bus.addr == timer_pkg::RELOAD_BASE ##2
        bus.rd && bus.addr == timer_pkg::RELOAD_BASE |=> rdata == $past(wd, 3))
        else $error("reload readback wrong");
    chk_ctrl1_back: assert property (
        bus.wr && bus.addr == 8'h08 ##2 bus.rd && bus.addr == 8'h08
        |=> rdata[7:0] == {2'h0, $past(wd[5:0], 3)})
        else $error("channel 1 control readback wrong");
    chk_cap_irq_gate: assert property (
        wr_ctl2 && bus.wdata[7:6] != 2'b11 |=> !capture_interrupt)
        else $error("capture interrupt without mode 11");
    chk_unf_irq_gate: assert property (
        wr_ctl2 && !bus.wdata[5] |=> !underflow_interrupt[2])
        else $error("underflow interrupt while disabled");
    chk_cap_stable: assert property (
        rd_cap && quiet_q > 4'h6 ##1 quiet_q > 4'h6 ##1 rd_cap |=> rdata == $past(rdata, 2))
        else $error("capture changed without pin edge");
    chk_cap_cause: assert property (
        $rose(capture_interrupt) && !$past(wr_s) |-> quiet_q < 4'h8)
        else $error("capture interrupt without pin edge");
    cov_cap_irq: cover property ($rose(capture_interrupt));
    cov_unf_irq: cover property ($rose(underflow_interrupt[0]));
    cov_cap_read: cover property (rd_cap);
endmodule

bind reload_timer_with_capture timer_monitor #(.CHANNELS(CHANNELS)) timer_monitor_inst (
    .mclk(mclk),
    .reset(reset),
    .bus(bus),
    .rdata(rdata),
    .external_timer_pin(external_timer_pin),
    .underflow_interrupt(underflow_interrupt),
    .capture_interrupt(capture_interrupt)
);

/* verification/pin_source.sv */
// Purpose: Event source on the external timer pin
// Assumes: Pin low after reset
// Notes:   Each level held HOLD clocks, enough for both-edge use
module pin_source #(
    parameter int HOLD = 4
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic start,
    input wire logic [3:0] n_edges,
    output logic busy,
    output logic pin
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] left_q;
    logic [3:0] hold_q;
    assign busy = left_q != 4'h0 || hold_q != 4'h0;
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            left_q <= 4'h0;
            hold_q <= 4'h0;
            pin <= 1'b0;
        end
        else if (start && !busy)
            left_q <= n_edges;
        else if (hold_q != 4'h0)
            hold_q <= hold_q - 4'h1;
        else if (left_q != 4'h0)
        begin
            pin <= !pin;
            left_q <= left_q - 4'h1;
            hold_q <= 4'(HOLD - 1);
        end
    end
endmodule

/* verification/tb_top.sv */
// Purpose: Register-level test of the reload timer
// Assumes: ce stays high
// Notes:   Count windows are whole multiples of the divider
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    timer_pkg::bus_req_s bus = '0;
    logic [31:0] rdata;
    logic pin;
    logic [2:0] underflow_interrupt;
    logic capture_interrupt;
    logic start = 1'b0;
    logic [3:0] n_edges = 4'h0;
    logic busy;
    int miscompares = 0;
    int n_tests = 0;

    reload_timer_with_capture reload_timer_with_capture_inst (.mclk(mclk), .reset(reset),
        .ce(1'b1), .bus(bus), .rdata(rdata), .external_timer_pin(pin),
        .underflow_interrupt(underflow_interrupt), .capture_interrupt(capture_interrupt));
    pin_source pin_source_inst (.mclk(mclk), .reset(reset), .start(start),
        .n_edges(n_edges), .busy(busy), .pin(pin));

    initial
    begin
        forever #10 mclk = ~mclk;
    end

    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge mclk);
        bus.wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
        @(posedge mclk);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge mclk);
        bus.rd <= 1'b0;
        #1;
        check(rdata & m, exp & m);
    endtask
    task automatic pulse(input logic [3:0] n);
        @(posedge mclk);
        start <= 1'b1;
        n_edges <= n;
        @(posedge mclk);
        start <= 1'b0;
        #1;
        for (int i = 0; i < 200 && busy; i++)
            @(posedge mclk);
        check({31'h0, busy}, 32'h0);
        repeat (6) @(posedge mclk);
        #1;
    endtask
    function automatic logic [7:0] at(input logic [7:0] base, input int i);
        return base + 8'(4 * i);
    endfunction
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        repeat (50000) @(posedge mclk);
        miscompares++;
        print_verdict();
    end

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial
    begin
        int divs [5] = '{4, 16, 64, 256, 0};
        logic [11:0] cctl [7] = '{12'h0c0, 12'h0c0, 12'h0c8, 12'h088, 12'h0d0, 12'h010, 12'h050};
        logic [11:0] ccnt [7] = '{12'h3e8, 12'h1f4, 12'h190, 12'h12c, 12'h0c8, 12'h064, 12'h032};
        logic [6:0] hit = 7'b0011001;
        logic [31:0] cap;
        int ch;
        repeat (10) @(posedge mclk);
        reset <= 1'b0;
        for (int i = 0; i < 3; i++)
        begin
            rd(at(timer_pkg::CTRL_BASE, i), 32'h0, '1);
            rd(at(timer_pkg::RELOAD_BASE, i), timer_pkg::RELOAD_RST, '1);
            rd(at(timer_pkg::COUNT_BASE, i), timer_pkg::COUNT_RST, '1);
        end
        rd(timer_pkg::RUN_OFF, 32'h0, '1);
        wr(timer_pkg::RELOAD_BASE, 32'ha5c3_0f96);
        rd(timer_pkg::RELOAD_BASE, 32'ha5c3_0f96, '1);
        wr(timer_pkg::COUNT_BASE, 32'h1234_5678);
        rd(timer_pkg::COUNT_BASE, 32'h1234_5678, '1);
        rd(timer_pkg::COUNT_BASE, 32'h1234_5678, '1);
        // Reserved bits written as ones on purpose
        wr(8'h08, 32'h0000_fc2b);
        rd(8'h08, 32'h0000_002b, 32'hffff_feff);
        wr(8'h2c, 32'h1);
        rd(8'h2c, 32'h0, '1);
        for (int k = 0; k < 5; k++)
        begin
            ch = k % 3;
            wr(at(timer_pkg::CTRL_BASE, ch), 32'h20 | 32'(k));
            wr(at(timer_pkg::COUNT_BASE, ch), 32'h3);
            wr(at(timer_pkg::RELOAD_BASE, ch), 32'h6);
            wr(timer_pkg::RUN_OFF, 32'h1 << ch);
            repeat ((divs[k] == 0 ? 40 : 10 * divs[k]) - 2) @(posedge mclk);
            wr(timer_pkg::RUN_OFF, 32'h0);
            rd(at(timer_pkg::COUNT_BASE, ch), divs[k] == 0 ? 32'h3 : 32'h0, '1);
            rd(at(timer_pkg::CTRL_BASE, ch), {23'h0, divs[k] != 0, 8'h0}, 32'h100);
            check({31'h0, underflow_interrupt[ch]}, {31'h0, divs[k] != 0});
            wr(at(timer_pkg::CTRL_BASE, ch), 32'h100 | 32'(k));
            rd(at(timer_pkg::CTRL_BASE, ch), {23'h0, divs[k] != 0, 8'h0}, 32'h100);
            check({31'h0, underflow_interrupt[ch]}, 32'h0);
            wr(at(timer_pkg::CTRL_BASE, ch), 32'h0);
            rd(at(timer_pkg::CTRL_BASE, ch), 32'h0, 32'h100);
        end
        for (int e = 0; e < 3; e++)
        begin
            wr(8'h08, 32'h5 | 32'(e << 3));
            wr(at(timer_pkg::COUNT_BASE, 1), 32'h64);
            wr(timer_pkg::RUN_OFF, 32'h2);
            pulse(4'h4);
            wr(timer_pkg::RUN_OFF, 32'h0);
            rd(at(timer_pkg::COUNT_BASE, 1), e == 2 ? 32'h60 : 32'h62, '1);
        end
        // Halted counter gives an exact capture value
        for (int k = 0; k < 7; k++)
        begin
            wr(8'h0c, {20'h0, cctl[k]});
            wr(at(timer_pkg::COUNT_BASE, 2), {20'h0, ccnt[k]});
            pulse(4'h1);
            if (hit[k])
                cap = {20'h0, ccnt[k]};
            rd(timer_pkg::CAPTURE_OFF, cap, '1);
            rd(timer_pkg::CAPTURE_OFF, cap, '1);
            rd(8'h0c, {22'h0, hit[k], 9'h0}, 32'h200);
            check({31'h0, capture_interrupt}, {31'h0, hit[k] && cctl[k][7:6] == 2'b11});
        end
        wr(timer_pkg::CAPTURE_OFF, 32'h0);
        rd(timer_pkg::CAPTURE_OFF, cap, '1);
        print_verdict();
    end
endmodule
